// ### design/asmr_pkg.sv
// Constants for the converter status, mode and register select block
// Functional notes
// - Select zero writes the command byte, reads the status byte; both 8 bits
// - Select three reads the result, 24 bits or 32 with status appended
// - Status byte is read-only, resets to 0x80, read via select zero
// - Ready bit clears on new result, sets after result read or before update
// - Ready sets on power-down, idle or restart pin low; output pin mirrors it
// - Error bit updates with ready; one when stored result was clamped
// - With watch enabled, missing reference sets flag and clamps result to ones
// - With parity enabled, bit 4 is one for odd count of result ones
// - Status bit 3 always reads zero
// - Bits 2:0 hold the channel of the stored result
// - Mode word resets to 0x080060; each write resets modulator and sets ready
// - Top three mode bits select operating mode, sent first
// - Append bit makes the status byte follow each result read
// - Clock field picks crystal, external, internal, or internal driven out
// - Bit 15 picks third order filter; settling three or four periods
// - Bit 13 enables parity; host should also set append
// - Bit 12 halves the master clock; host normally leaves it clear
// - Bit 11 gives one-period settling unless multichannel or single mode
// - Bit 10 adds a 60 Hz notch when first notch sits at 50 Hz
// - Rate word divides master clock over 1024 to set output rate
// - With chopping the rate is further divided by the filter order
// - Each access starts with a command byte, then returns to command wait
// - Mode 001 powers up, converts once, stores, drives ready low, powers down
package asmr_pkg;
   localparam logic [2:0] SEL_STATUS = 3'h0;
   localparam logic [2:0] SEL_MODE = 3'h1;
   localparam logic [2:0] SEL_SETUP = 3'h2;
   localparam logic [2:0] SEL_RESULT = 3'h3;
   localparam logic [2:0] SEL_IDENT = 3'h4;
   localparam logic [2:0] SEL_DOUT = 3'h5;
   localparam logic [2:0] SEL_ZERO = 3'h6;
   localparam logic [2:0] SEL_SPAN = 3'h7;
   localparam logic [7:0] FLAGS_RESET = 8'h80;
   localparam logic [23:0] MODE_RESET = 24'h080060;
   localparam int CMD_RW = 6;
   localparam int CMD_SEL_LSB = 3;
   localparam int ST_READY = 7;
   localparam int MD_LSB = 21;
   localparam int MD_APPEND = 20;
   localparam int MD_CLK_LSB = 18;
   localparam int MD_FILT3 = 15;
   localparam int MD_PARITY = 13;
   localparam int MD_CLKDIV = 12;
   localparam int MD_ONECYC = 11;
   localparam int MD_NOTCH = 10;
   localparam int FS_W = 10;
   localparam logic [2:0] MODE_CONT = 3'h0;
   localparam logic [2:0] MODE_SINGLE = 3'h1;
   localparam logic [2:0] MODE_IDLE = 3'h2;
   localparam logic [2:0] MODE_PDOWN = 3'h3;
   localparam logic [1:0] CLK_XTAL = 2'h0;
   localparam logic [1:0] CLK_EXT = 2'h1;
   localparam logic [1:0] CLK_INT = 2'h2;
   localparam logic [1:0] CLK_INT_OUT = 2'h3;
   localparam logic [5:0] LEN_SHORT = 6'h08;
   localparam logic [5:0] LEN_LONG = 6'h18;
   localparam logic [5:0] LEN_APPEND = 6'h20;
   localparam logic [10:0] PRESCALE = 11'h400;
   localparam logic [2:0] SETTLE_ONE = 3'h1;
   localparam logic [2:0] SETTLE_THIRD = 3'h3;
   localparam logic [2:0] SETTLE_FOURTH = 3'h4;
   typedef enum logic [2:0] {
      ASMR_ST_CMD = 3'b001,
      ASMR_ST_WR = 3'b010,
      ASMR_ST_RD = 3'b100
   } asmr_state_t;
endpackage

// ### design/asmr_rate_div.sv
// Tick divider stage of the output rate chain
`timescale 1ns/100ps
module asmr_rate_div #(
   parameter int W = 10
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clr,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic pulse
);
   logic [W-1:0] cnt_q;
   logic pulse_q;
   // A limit of zero wraps and divides by two to the W
   wire [W-1:0] last = limit - W'(1);
   wire at_end = tick && (cnt_q == last);

   always_ff @(posedge ref_clk) begin
      if (rst || clr) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         pulse_q <= at_end;
         if (at_end) begin
            cnt_q <= '0;
         end else if (tick) begin
            cnt_q <= cnt_q + W'(1);
         end
      end
   end

   assign pulse = pulse_q;
endmodule // asmr_rate_div

// ### design/asmr_top.sv
// Serial register port, status flags and mode control of the converter
`timescale 1ns/100ps
module asmr_top #(
   // Arbitrary identity value
   parameter logic [7:0] IDENT_CODE = 8'h5a,
   // Rate word that places the first notch at 50 Hz
   parameter logic [9:0] NOTCH50_FS = 10'h060
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   input wire logic conv_valid,
   input wire logic [23:0] conv_result,
   input wire logic [2:0] conv_channel,
   input wire logic conv_clamped,
   input wire logic pre_update,
   input wire logic sync_n,
   input wire logic reference_watch_enable,
   input wire logic reference_below_threshold,
   input wire logic chop_enable,
   input wire logic multi_channel,
   input wire logic osc_level,
   input wire logic master_clock_pin_b_in,
   output logic master_clock_pin_b_out,
   output logic master_clock_pin_b_oe,
   output logic crystal_enable,
   output logic conv_start,
   output logic modulator_reset,
   output logic converter_active,
   output logic [2:0] operating_mode_select,
   output logic third_order_filter_select,
   output logic [2:0] settle_periods,
   output logic extra_notch_active
);
   asmr_pkg::asmr_state_t st_q;
   logic sclk_q;
   logic [23:0] rx_q;
   logic [31:0] tx_q;
   logic [5:0] bit_cnt_q;
   logic [5:0] len_q;
   logic [2:0] sel_q;
   logic dout_q;
   logic [23:0] mode_q;
   logic [23:0] store_q [8];
   logic [23:0] result_q;
   logic rdy_n_q;
   logic err_q;
   logic reference_missing_flag_q;
   logic [2:0] chan_q;
   logic mclk_lvl_q;
   logic half_q;
   logic single_done_q;
   logic conv_start_q;
   logic mod_reset_q;
   logic active_q;
   logic xtal_q;
   logic pin_b_oe_q;
   logic pin_b_out_q;
   logic [2:0] settle_q;
   logic notch_q;
   logic pre_p;
   logic fs_p;
   logic ord_p;

   // Serial edges; pins are synchronous to ref_clk
   wire sclk_rise = sclk && !sclk_q && !cs_n;
   wire sclk_fall = !sclk && sclk_q && !cs_n;
   wire in_cmd = (st_q == asmr_pkg::ASMR_ST_CMD);
   wire in_rd = (st_q == asmr_pkg::ASMR_ST_RD);
   wire in_wr = (st_q == asmr_pkg::ASMR_ST_WR);

   // Command byte decode
   wire [7:0] cmd_w = {rx_q[6:0], din};
   wire [23:0] wr_data = {rx_q[22:0], din};
   wire cmd_read = cmd_w[asmr_pkg::CMD_RW];
   wire [2:0] cmd_sel = cmd_w[asmr_pkg::CMD_SEL_LSB +: 3];
   wire wen_hold = in_cmd && sclk_rise && (bit_cnt_q == 6'h00) && din;
   wire cmd_done = in_cmd && sclk_rise && !wen_hold &&
      (bit_cnt_q == asmr_pkg::LEN_SHORT - 6'h01);
   wire word_done = !in_cmd && sclk_rise && (bit_cnt_q == len_q - 6'h01);
   wire mode_write = word_done && in_wr && (sel_q == asmr_pkg::SEL_MODE);
   wire store_write = word_done && in_wr &&
      ((sel_q == asmr_pkg::SEL_SETUP) || (sel_q == asmr_pkg::SEL_DOUT) ||
       (sel_q == asmr_pkg::SEL_ZERO) || (sel_q == asmr_pkg::SEL_SPAN));
   wire result_read = word_done && in_rd && (sel_q == asmr_pkg::SEL_RESULT);

   // Mode fields
   wire [2:0] op_mode = mode_q[asmr_pkg::MD_LSB +: 3];
   wire append_state_byte = mode_q[asmr_pkg::MD_APPEND];
   wire [1:0] clock_source_select = mode_q[asmr_pkg::MD_CLK_LSB +: 2];
   wire filt3 = mode_q[asmr_pkg::MD_FILT3];
   wire parity_check_enable = mode_q[asmr_pkg::MD_PARITY];
   wire half_clock = mode_q[asmr_pkg::MD_CLKDIV];
   wire one_cycle = mode_q[asmr_pkg::MD_ONECYC];
   wire extra_notch_enable = mode_q[asmr_pkg::MD_NOTCH];
   wire [9:0] rate_divider_word = mode_q[asmr_pkg::FS_W-1:0];

   // Status byte assembly
   wire parity_bit = parity_check_enable && (^result_q);
   wire [7:0] status_w = {rdy_n_q, err_q, reference_missing_flag_q, parity_bit,
      1'b0, chan_q};

   // Access lengths and read word, left aligned for MSB-first shifting
   wire short_sel = (cmd_sel == asmr_pkg::SEL_STATUS) ||
      (cmd_sel == asmr_pkg::SEL_IDENT) || (cmd_sel == asmr_pkg::SEL_DOUT);
   wire append_rd = (cmd_sel == asmr_pkg::SEL_RESULT) && append_state_byte;
   wire [5:0] rd_len = short_sel ? asmr_pkg::LEN_SHORT :
      append_rd ? asmr_pkg::LEN_APPEND : asmr_pkg::LEN_LONG;
   wire [5:0] wr_len = short_sel ? asmr_pkg::LEN_SHORT : asmr_pkg::LEN_LONG;
   wire [23:0] store_rd = store_q[cmd_sel];
   wire [31:0] rd_word =
      (cmd_sel == asmr_pkg::SEL_STATUS) ? {status_w, 24'h000000} :
      (cmd_sel == asmr_pkg::SEL_MODE) ? {mode_q, 8'h00} :
      (cmd_sel == asmr_pkg::SEL_RESULT) ? {result_q, status_w} :
      (cmd_sel == asmr_pkg::SEL_IDENT) ? {IDENT_CODE, 24'h000000} :
      (cmd_sel == asmr_pkg::SEL_DOUT) ? {store_rd[7:0], 24'h000000} :
      {store_rd, 8'h00};

   // Serial access sequencer
   always_ff @(posedge ref_clk) begin
      if (rst || cs_n) begin
         st_q <= asmr_pkg::ASMR_ST_CMD;
         bit_cnt_q <= 6'h00;
         len_q <= asmr_pkg::LEN_SHORT;
         sel_q <= asmr_pkg::SEL_STATUS;
      end else if (cmd_done) begin
         bit_cnt_q <= 6'h00;
         sel_q <= cmd_sel;
         if (cmd_read) begin
            st_q <= asmr_pkg::ASMR_ST_RD;
            len_q <= rd_len;
         end else if (cmd_sel == asmr_pkg::SEL_STATUS) begin
            st_q <= asmr_pkg::ASMR_ST_CMD;
         end else begin
            st_q <= asmr_pkg::ASMR_ST_WR;
            len_q <= wr_len;
         end
      end else if (word_done) begin
         st_q <= asmr_pkg::ASMR_ST_CMD;
         bit_cnt_q <= 6'h00;
      end else if (sclk_rise && !wen_hold) begin
         bit_cnt_q <= bit_cnt_q + 6'h01;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sclk_q <= 1'b1;
         rx_q <= 24'h000000;
      end else begin
         sclk_q <= sclk;
         if (sclk_rise) begin
            rx_q <= wr_data;
         end
      end
   end

   // Transmit shifter; idle output mirrors the ready bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_q <= 32'h00000000;
         dout_q <= 1'b1;
      end else if (cmd_done && cmd_read) begin
         tx_q <= rd_word;
      end else if (in_rd && !cs_n) begin
         if (sclk_fall) begin
            dout_q <= tx_q[31];
            tx_q <= {tx_q[30:0], 1'b0};
         end
      end else begin
         dout_q <= rdy_n_q;
      end
   end

   // Register storage; mode writes ignore nothing, host keeps bits zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_q <= asmr_pkg::MODE_RESET;
         for (int i = 0; i < 8; i++) begin
            store_q[i] <= 24'h000000;
         end
      end else begin
         if (mode_write) begin
            mode_q <= wr_data;
         end
         if (store_write) begin
            store_q[sel_q] <= wr_data;
         end
      end
   end

   // Result capture and status flags
   wire [23:0] stored_result = reference_missing_flag_q ? 24'hffffff : conv_result;
   wire rdy_set = result_read || pre_update || mode_write || !sync_n;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdy_n_q <= asmr_pkg::FLAGS_RESET[asmr_pkg::ST_READY];
         err_q <= 1'b0;
         reference_missing_flag_q <= 1'b0;
         chan_q <= 3'h0;
         result_q <= 24'h000000;
      end else begin
         reference_missing_flag_q <= reference_watch_enable && reference_below_threshold;
         if (conv_valid) begin
            rdy_n_q <= 1'b0;
            err_q <= conv_clamped || reference_missing_flag_q;
            chan_q <= conv_channel;
            result_q <= stored_result;
         end else if (rdy_set) begin
            rdy_n_q <= 1'b1;
         end
      end
   end

   // Master clock source and optional halving
   wire ext_src = (clock_source_select == asmr_pkg::CLK_XTAL) ||
      (clock_source_select == asmr_pkg::CLK_EXT);
   wire src_level = ext_src ? master_clock_pin_b_in : osc_level;
   wire mclk_tick = src_level && !mclk_lvl_q;
   wire div_tick = half_clock ? (mclk_tick && half_q) : mclk_tick;
   wire running = (op_mode == asmr_pkg::MODE_CONT) ||
      ((op_mode == asmr_pkg::MODE_SINGLE) && !single_done_q);
   wire chain_clr = mod_reset_q || !running;
   wire [2:0] order = filt3 ? asmr_pkg::SETTLE_THIRD :
      asmr_pkg::SETTLE_FOURTH;
   wire [2:0] chop_div = chop_enable ? order : asmr_pkg::SETTLE_ONE;
   wire zero_lat = one_cycle && !multi_channel &&
      (op_mode != asmr_pkg::MODE_SINGLE);
   wire notch_50 = (rate_divider_word == NOTCH50_FS) && !half_clock;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mclk_lvl_q <= 1'b0;
         half_q <= 1'b0;
         single_done_q <= 1'b0;
         conv_start_q <= 1'b0;
         mod_reset_q <= 1'b1;
         active_q <= 1'b0;
         xtal_q <= 1'b0;
         pin_b_oe_q <= 1'b0;
         pin_b_out_q <= 1'b0;
         settle_q <= asmr_pkg::SETTLE_FOURTH;
         notch_q <= 1'b0;
      end else begin
         mclk_lvl_q <= src_level;
         if (mclk_tick) begin
            half_q <= !half_q;
         end
         if (mode_write) begin
            single_done_q <= 1'b0;
         end else if (conv_valid && (op_mode == asmr_pkg::MODE_SINGLE)) begin
            single_done_q <= 1'b1;
         end
         conv_start_q <= ord_p && running;
         mod_reset_q <= mode_write || (op_mode == asmr_pkg::MODE_IDLE);
         active_q <= running;
         xtal_q <= (clock_source_select == asmr_pkg::CLK_XTAL);
         pin_b_oe_q <= (clock_source_select == asmr_pkg::CLK_INT_OUT);
         pin_b_out_q <= osc_level;
         settle_q <= zero_lat ? asmr_pkg::SETTLE_ONE : order;
         notch_q <= extra_notch_enable && notch_50;
      end
   end

   // Rate chain: 1024 prescale, rate word, then chop order
   asmr_rate_div #(.W(11)) u_pre (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(chain_clr),
      .tick(div_tick),
      .limit(asmr_pkg::PRESCALE),
      .pulse(pre_p)
   );

   asmr_rate_div #(.W(10)) u_fs (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(chain_clr),
      .tick(pre_p),
      .limit(rate_divider_word),
      .pulse(fs_p)
   );

   asmr_rate_div #(.W(3)) u_ord (
      .ref_clk(ref_clk),
      .rst(rst),
      .clr(chain_clr),
      .tick(fs_p),
      .limit(chop_div),
      .pulse(ord_p)
   );

   assign dout = dout_q;
   assign master_clock_pin_b_out = pin_b_out_q;
   assign master_clock_pin_b_oe = pin_b_oe_q;
   assign crystal_enable = xtal_q;
   assign conv_start = conv_start_q;
   assign modulator_reset = mod_reset_q;
   assign converter_active = active_q;
   assign operating_mode_select = op_mode;
   assign third_order_filter_select = filt3;
   assign settle_periods = settle_q;
   assign extra_notch_active = notch_q;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence status_cmd_s;
      cmd_done && cmd_read && (cmd_sel == asmr_pkg::SEL_STATUS);
   endsequence

   sequence append_cmd_s;
      cmd_done && cmd_read && (cmd_sel == asmr_pkg::SEL_RESULT) &&
         append_state_byte;
   endsequence

   status_load_a: assert property (status_cmd_s |=>
      in_rd && (len_q == 6'h08) && (tx_q[31:24] == $past(status_w)))
      else $error("status read not loaded");
   append_len_a: assert property (append_cmd_s |=>
      (len_q == 6'h20) && (tx_q[7:0] == $past(status_w)))
      else $error("appended status missing");
   rdy_clear_a: assert property (conv_valid |=> !rdy_n_q)
      else $error("ready not cleared by result");
   rdy_read_a: assert property (result_read && !conv_valid |=> rdy_n_q)
      else $error("ready not set after read");
   sync_ready_a: assert property (!sync_n && !conv_valid |=> rdy_n_q)
      else $error("ready not set by restart");
   mode_wr_a: assert property (mode_write && !conv_valid |=>
      rdy_n_q && mod_reset_q && (mode_q == $past(wr_data)))
      else $error("mode write effects missing");
   err_track_a: assert property (conv_valid |=>
      err_q == $past(conv_clamped || reference_missing_flag_q))
      else $error("error bit wrong");
   clamp_ones_a: assert property (conv_valid && reference_missing_flag_q |=>
      result_q == 24'hffffff)
      else $error("result not clamped");
   chan_hold_a: assert property (!conv_valid |=> $stable(chan_q))
      else $error("channel tag moved");
   single_stop_a: assert property (conv_valid &&
      (op_mode == asmr_pkg::MODE_SINGLE) && !mode_write ##1 !mode_write
      |=> ##1 !converter_active)
      else $error("single mode did not stop");
   wen_hold_a: assert property (wen_hold |=> bit_cnt_q == 6'h00)
      else $error("command started on high bit");
   pin_drive_a: assert property ((clock_source_select ==
      asmr_pkg::CLK_INT) [*2] |-> !master_clock_pin_b_oe)
      else $error("clock pin driven");
endmodule // asmr_top

// ### tb/asmr_host.sv
// Host serial port model driving the register interface
`timescale 1ns/100ps
module asmr_host (
   input wire logic ref_clk,
   input wire logic dout,
   output logic cs_n,
   output logic sclk,
   output logic din,
   output logic rd_valid,
   output logic [31:0] rd_data
);
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b1;
      rd_valid = 1'b0;
      rd_data = 32'h0;
   end

   // Command byte first, then nbits of data, MSB first
   task automatic xfer(input logic [7:0] cmd, input int nbits,
                       input logic [31:0] wd);
      logic [31:0] got;
      logic b;
      got = 32'h0;
      for (int i = 0; i < 8 + nbits; i++) begin
         b = (i < 8) ? cmd[7-i] : wd[nbits-1-(i-8)];
         @(posedge ref_clk);
         cs_n <= 1'b0;
         sclk <= 1'b0;
         din <= b;
         repeat (3) @(posedge ref_clk);
         got = {got[30:0], dout};
         sclk <= 1'b1;
         repeat (2) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      // Idle data high between frames
      cs_n <= 1'b1;
      din <= 1'b1;
      if (cmd[6]) begin
         rd_data <= got & 32'((64'h1 << nbits) - 64'h1);
         rd_valid <= 1'b1;
         @(posedge ref_clk);
         rd_valid <= 1'b0;
      end
      repeat (2) @(posedge ref_clk);
   endtask
endmodule // asmr_host

// ### tb/test_asmr_top.sv
// Self-checking bench for the status, mode and register select block
`timescale 1ns/100ps
module test_asmr_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sclk, din, dout, rd_valid;
   logic [31:0] rd_data;
   logic conv_valid = 1'b0;
   logic [23:0] conv_result = 24'h0;
   logic [2:0] conv_channel = 3'h0;
   logic conv_clamped = 1'b0;
   logic pre_update = 1'b0;
   logic sync_n = 1'b1;
   logic ref_watch = 1'b0;
   logic ref_low = 1'b0;
   logic chop_enable = 1'b0;
   logic multi_channel = 1'b0;
   logic osc_level = 1'b0;
   logic pin_b_out, pin_b_oe, crystal_enable, conv_start, modulator_reset;
   logic converter_active, third_sel, extra_notch;
   logic [2:0] op_mode, settle;
   logic [31:0] exp_q[$];
   int n_fail = 0;
   int tests_run = 0;
   int seed = 32'h06a08355;
   int n;
   logic [23:0] r;
   logic [2:0] ch;

   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) osc_level <= ~osc_level;

   // Arbitrary identity value
   asmr_top #(.IDENT_CODE(8'h3c)) i_asmr_top (.ref_clk(ref_clk), .rst(rst),
      .cs_n(cs_n),
      .sclk(sclk), .din(din), .dout(dout), .conv_valid(conv_valid),
      .conv_result(conv_result), .conv_channel(conv_channel),
      .conv_clamped(conv_clamped), .pre_update(pre_update),
      .sync_n(sync_n), .reference_watch_enable(ref_watch),
      .reference_below_threshold(ref_low), .chop_enable(chop_enable),
      .multi_channel(multi_channel), .osc_level(osc_level),
      .master_clock_pin_b_in(~osc_level),
      .master_clock_pin_b_out(pin_b_out),
      .master_clock_pin_b_oe(pin_b_oe), .crystal_enable(crystal_enable),
      .conv_start(conv_start), .modulator_reset(modulator_reset),
      .converter_active(converter_active), .operating_mode_select(op_mode),
      .third_order_filter_select(third_sel), .settle_periods(settle),
      .extra_notch_active(extra_notch));

   asmr_host i_asmr_host (.ref_clk(ref_clk), .dout(dout), .cs_n(cs_n),
      .sclk(sclk), .din(din), .rd_valid(rd_valid), .rd_data(rd_data));

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Oldest expected read value against each returned frame
   always @(posedge ref_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk("unexpected read", 32'h0, 32'h1);
         else chk("read data", exp_q.pop_front(), rd_data);
      end
   end

   task automatic rd(logic [2:0] sel, int nb, logic [31:0] e);
      exp_q.push_back(e);
      i_asmr_host.xfer({2'b01, sel, 3'b000}, nb, 32'h0);
   endtask

   task automatic wrm(logic [23:0] d);
      // Reserved bits and clock halving kept clear by the host
      i_asmr_host.xfer(8'h08, 24, {8'h0, d & 24'hfcafff});
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic conv(logic [23:0] res, logic [2:0] c, logic cl);
      @(posedge ref_clk);
      conv_valid <= 1'b1;
      conv_result <= res;
      conv_channel <= c;
      conv_clamped <= cl;
      @(posedge ref_clk);
      conv_valid <= 1'b0;
      conv_clamped <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask

   function automatic logic [7:0] sts(logic rdy, logic er, logic nr,
                                      logic [23:0] v, logic [2:0] c);
      return {rdy, er, nr, ^v, 1'b0, c};
   endfunction

   task automatic gap(output int k);
      int i;
      i = 0;
      while (conv_start !== 1'b1 && i < 20000) begin
         @(posedge ref_clk);
         i++;
      end
      @(posedge ref_clk);
      k = 1;
      while (conv_start !== 1'b1 && k < 20000) begin
         @(posedge ref_clk);
         k++;
      end
   endtask

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      #400000;
      n_fail++;
      give_verdict();
   end

   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("ready pin", 32'h1, {31'h0, dout});
      chk("settle", 32'h4, {29'h0, settle});
      chk("crystal", 32'h0, {31'h0, crystal_enable});
      rd(3'h0, 8, 32'h80);
      rd(3'h1, 24, 32'h080060);
      rd(3'h4, 8, 32'h3c);
      $display("test reset done");

      wrm(24'h182001);
      for (int k = 0; k < 2; k++) begin
         r = $random(seed);
         ch = $random(seed);
         conv(r, ch, 1'b0);
         chk("ready pin", 32'h0, {31'h0, dout});
         rd(3'h0, 8, sts(0, 0, 0, r, ch));
         rd(3'h3, 32, {r, sts(0, 0, 0, r, ch)});
         rd(3'h0, 8, sts(1, 0, 0, r, ch));
      end
      $display("test result done");

      r = $random(seed);
      conv(r, 3'h5, 1'b1);
      rd(3'h0, 8, sts(0, 1, 0, r, 3'h5));
      ref_watch <= 1'b1;
      ref_low <= 1'b1;
      repeat (3) @(posedge ref_clk);
      conv(r, 3'h2, 1'b0);
      rd(3'h3, 32, {24'hffffff, sts(0, 1, 1, 24'hffffff, 3'h2)});
      ref_low <= 1'b0;
      repeat (3) @(posedge ref_clk);
      conv(r, 3'h6, 1'b0);
      rd(3'h0, 8, sts(0, 0, 0, r, 3'h6));
      ref_watch <= 1'b0;
      $display("test error flags done");

      conv(r, 3'h1, 1'b0);
      pre_update <= 1'b1;
      @(posedge ref_clk);
      pre_update <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("ready pin", 32'h1, {31'h0, dout});
      conv(r, 3'h1, 1'b0);
      sync_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      sync_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk("ready pin", 32'h1, {31'h0, dout});
      for (int m = 0; m < 4; m++) begin
         if (m != 1) begin
            conv(r, 3'h1, 1'b0);
            wrm({m[2:0], 21'h080001});
            chk("ready pin", 32'h1, {31'h0, dout});
            chk("mode", m, {29'h0, op_mode});
         end
      end
      chk("idle reset", 32'h0, {31'h0, modulator_reset});
      wrm(24'h480001);
      chk("idle reset", 32'h1, {31'h0, modulator_reset});
      $display("test ready events done");

      for (int c = 0; c < 4; c++) begin
         wrm({4'h0, c[1:0], 18'h1});
         chk("crystal", c == 0, {31'h0, crystal_enable});
         chk("pin drive", c == 3, {31'h0, pin_b_oe});
         chk("pin out", {31'h0, ~osc_level}, {31'h0, pin_b_out});
      end
      for (int k = 0; k < 8; k++) begin
         multi_channel <= k[2];
         wrm(24'h080001 | (k[0] << 15) | (k[1] << 11));
         chk("filter", k[0], {31'h0, third_sel});
         chk("settle", (k[1] && !k[2]) ? 1 : (k[0] ? 3 : 4),
             {29'h0, settle});
      end
      multi_channel <= 1'b0;
      wrm(24'h080460);
      chk("notch", 32'h1, {31'h0, extra_notch});
      wrm(24'h080461);
      chk("notch", 32'h0, {31'h0, extra_notch});
      $display("test mode fields done");

      wrm(24'h280001);
      chk("active", 32'h1, {31'h0, converter_active});
      conv(r, 3'h4, 1'b0);
      repeat (3) @(posedge ref_clk);
      chk("active", 32'h0, {31'h0, converter_active});
      chk("ready pin", 32'h0, {31'h0, dout});
      $display("test single done");

      wrm(24'h080001);
      gap(n);
      gap(n);
      chk("rate gap", 32'd2048, n);
      chop_enable <= 1'b1;
      gap(n);
      gap(n);
      chk("chop gap", 32'd8192, n);
      $display("test rate done");
      give_verdict();
   end
endmodule // test_asmr_top
